// File: hw/timer_pair.sv
// Timer pair with AXI4-Lite registers, 16/32-bit modes and event interrupt
// How it works
// - With idle halt set the timer stops while the device idles, otherwise it keeps running.
// - With the external pin as count source the gated accumulate bit changes nothing.
// - With the internal clock, gated accumulate counts only while the pin is high.
// - The prescale field divides the source by 1, 8, 64 or 256 for codes 00 to 11.
// - In 32-bit mode the upper timer's control settings do not act on the pair.
// - Unimplemented control bits ignore writes and read as zero.
// - With 32-bit mode off the lower run bit starts and stops an independent 16-bit timer.
// - In 32-bit mode the lower timer is the low word and the upper timer the high word.
// - In 32-bit mode the lower timer's inputs drive the pair and the upper flag raises events.
// - Bit 3 of the lower control register selects 32-bit mode.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module timer_pair #(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // Read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Device state and pins
  input wire logic idle_mode,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  // Interrupt
  output logic irq
);
  import timer_pair_pkg::*;

  logic [15:0] timer_a_control;
  logic [15:0] timer_b_control;
  logic [15:0] count_a;
  logic [15:0] count_b;
  logic [1:0] event_status;
  logic [1:0] event_mask;
  logic [1:0] events;
  logic [1:0] status_clear;

  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got, w_got;
  logic do_write;
  logic ar_take;
  logic [31:0] rd_word;
  logic rd_ok;

  logic pair_wide_mode;
  lane_cfg_t cfg_a, cfg_b;
  logic tick_a, tick_b;
  logic a_full, b_full;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16[7:0] = strb[0] ? d[7:0] : old[7:0];
    merge16[15:8] = strb[1] ? d[15:8] : old[15:8];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    case (a)
      `OFS_TIMER_A_CONTROL, `OFS_TIMER_B_CONTROL, `OFS_COUNT_A, `OFS_COUNT_B,
      `OFS_EVENT_STATUS, `OFS_EVENT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Mode and lane settings
  assign pair_wide_mode = timer_a_control[`FLD_PAIR_WIDE_MODE];
  assign cfg_a = cfg_of(timer_a_control);
  assign cfg_b = pair_wide_mode ? '0 : cfg_of(timer_b_control);

  timer_lane lane_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg_a),
    .idle_mode(idle_mode),
    .clock_pin(ext_clock_pin_a),
    .tick(tick_a)
  );

  timer_lane lane_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg_b),
    .idle_mode(idle_mode),
    .clock_pin(ext_clock_pin_b),
    .tick(tick_b)
  );

  assign a_full = count_a == 16'hffff;
  assign b_full = count_b == 16'hffff;

  // Lower count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_a <= 16'h0000;
    end else if (tick_a) begin
      count_a <= count_a + 16'h0001;
    end
  end

  // Upper count, carried from the lower word in 32-bit mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_b <= 16'h0000;
    end else if (pair_wide_mode) begin
      if (tick_a && a_full) begin
        count_b <= count_b + 16'h0001;
      end
    end else if (tick_b) begin
      count_b <= count_b + 16'h0001;
    end
  end

  // Wrap events
  always_comb begin
    events = 2'b00;
    events[`EVT_WRAP_A] = !pair_wide_mode && tick_a && a_full;
    if (pair_wide_mode) begin
      events[`EVT_WRAP_B] = tick_a && a_full && b_full;
    end else begin
      events[`EVT_WRAP_B] = tick_b && b_full;
    end
  end

  // Sticky status, cleared by reading it; a new event wins
  assign status_clear = (ar_take && araddr == `OFS_EVENT_STATUS) ? event_status : 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= 2'b00;
    end else begin
      event_status <= (event_status & ~status_clear) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((event_status & ~status_clear) | events) & event_mask);
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_got <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else begin
      awready <= !aw_got && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_got <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_got <= 1'b0;
    end else begin
      wready <= !w_got && !bvalid;
    end
  end

  assign do_write = aw_got && w_got && !bvalid;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_a_control <= `RST_TIMER_A_CONTROL;
      timer_b_control <= `RST_TIMER_B_CONTROL;
      event_mask <= 2'b00;
    end else if (do_write) begin
      case (aw_addr)
        `OFS_TIMER_A_CONTROL: begin
          timer_a_control <= merge16(timer_a_control, w_data, w_strb)
                             & `WMASK_TIMER_A_CONTROL;
        end
        `OFS_TIMER_B_CONTROL: begin
          timer_b_control <= merge16(timer_b_control, w_data, w_strb)
                             & `WMASK_TIMER_B_CONTROL;
        end
        `OFS_EVENT_MASK: begin
          if (w_strb[0]) begin
            event_mask <= w_data[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read path
  assign ar_take = arvalid && arready;

  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (araddr)
      `OFS_TIMER_A_CONTROL: rd_word[15:0] = timer_a_control;
      `OFS_TIMER_B_CONTROL: rd_word[15:0] = timer_b_control;
      `OFS_COUNT_A: rd_word[15:0] = count_a;
      `OFS_COUNT_B: rd_word[15:0] = count_b;
      `OFS_EVENT_STATUS: rd_word[1:0] = event_status;
      `OFS_EVENT_MASK: rd_word[1:0] = event_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else begin
      arready <= !rvalid;
    end
  end

  property p_upper_ignored;
    @(posedge aclk) disable iff (!aresetn)
    pair_wide_mode |=> !tick_b;
  endproperty
  a_upper_ignored: assert property (p_upper_ignored) else $error("upper lane ticked in wide mode");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    rvalid && $rose(rvalid) && ($past(araddr) == `OFS_TIMER_A_CONTROL ||
      $past(araddr) == `OFS_TIMER_B_CONTROL) |-> rdata[31:16] == 16'h0000 &&
      (rdata[15:0] & ~`WMASK_TIMER_A_CONTROL) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_lower_counts;
    @(posedge aclk) disable iff (!aresetn)
    !pair_wide_mode && tick_a |=> count_a == $past(count_a) + 16'h0001;
  endproperty
  a_lower_counts: assert property (p_lower_counts) else $error("lower count missed tick");

  property p_lower_stops;
    @(posedge aclk) disable iff (!aresetn)
    !timer_a_control[`FLD_TIMER_RUN] ##1 !timer_a_control[`FLD_TIMER_RUN] |=> $stable(count_a);
  endproperty
  a_lower_stops: assert property (p_lower_stops) else $error("stopped timer counted");

  property p_carry;
    @(posedge aclk) disable iff (!aresetn)
    pair_wide_mode && tick_a && a_full |=> count_a == 16'h0000 &&
      count_b == $past(count_b) + 16'h0001;
  endproperty
  a_carry: assert property (p_carry) else $error("no carry into upper word");

  property p_wide_event;
    @(posedge aclk) disable iff (!aresetn)
    pair_wide_mode && tick_a && a_full && b_full |=> event_status[`EVT_WRAP_B];
  endproperty
  a_wide_event: assert property (p_wide_event) else $error("32-bit wrap flag not raised");

  property p_wide_no_lower_event;
    @(posedge aclk) disable iff (!aresetn)
    pair_wide_mode |-> !events[`EVT_WRAP_A];
  endproperty
  a_wide_no_lower_event: assert property (p_wide_no_lower_event) else $error("lower flag in wide");

  property p_mode_bit;
    @(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == `OFS_TIMER_A_CONTROL && w_strb[0] |=>
      pair_wide_mode == $past(w_data[`FLD_PAIR_WIDE_MODE]);
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("mode bit not taken");

  property p_status_sticky;
    @(posedge aclk) disable iff (!aresetn)
    event_status[`EVT_WRAP_B] && !status_clear[`EVT_WRAP_B] |=> event_status[`EVT_WRAP_B];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

  property p_read_clears;
    @(posedge aclk) disable iff (!aresetn)
    ar_take && araddr == `OFS_EVENT_STATUS && events == 2'b00 |=> event_status == 2'b00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared");

endmodule

// File: hw/timer_pair_consts.svh
// Register offsets, field positions, reset values and prescale counts
`ifndef TIMER_PAIR_CONSTS_SVH
`define TIMER_PAIR_CONSTS_SVH

`define OFS_TIMER_A_CONTROL 5'h00
`define OFS_TIMER_B_CONTROL 5'h04
`define OFS_COUNT_A 5'h08
`define OFS_COUNT_B 5'h0c
`define OFS_EVENT_STATUS 5'h10
`define OFS_EVENT_MASK 5'h14

`define FLD_TIMER_RUN 15
`define FLD_IDLE_HALT 13
`define FLD_GATED_ACCUMULATE 6
`define FLD_PRESCALE_HI 5
`define FLD_PRESCALE_LO 4
`define FLD_PAIR_WIDE_MODE 3
`define FLD_COUNT_SOURCE_SEL 1

`define RST_TIMER_A_CONTROL 16'h0000
`define RST_TIMER_B_CONTROL 16'h0000
`define WMASK_TIMER_A_CONTROL 16'ha07a
`define WMASK_TIMER_B_CONTROL 16'ha072

`define EVT_WRAP_A 0
`define EVT_WRAP_B 1

`define PRESCALE_LAST_1 8'h00
`define PRESCALE_LAST_8 8'h07
`define PRESCALE_LAST_64 8'h3f
`define PRESCALE_LAST_256 8'hff

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: hw/timer_pair_pkg.sv
// Types and shared decoding for the timer pair
`include "timer_pair_consts.svh"
package timer_pair_pkg;

  typedef struct packed {
    logic run;
    logic idle_halt;
    logic gated_accumulate;
    logic [1:0] input_prescale_sel;
    logic count_source_sel;
  } lane_cfg_t;

  function automatic logic [7:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'b00: prescale_last = `PRESCALE_LAST_1;
      2'b01: prescale_last = `PRESCALE_LAST_8;
      2'b10: prescale_last = `PRESCALE_LAST_64;
      default: prescale_last = `PRESCALE_LAST_256;
    endcase
  endfunction

  function automatic lane_cfg_t cfg_of(input logic [15:0] ctrl);
    cfg_of.run = ctrl[`FLD_TIMER_RUN];
    cfg_of.idle_halt = ctrl[`FLD_IDLE_HALT];
    cfg_of.gated_accumulate = ctrl[`FLD_GATED_ACCUMULATE];
    cfg_of.input_prescale_sel = ctrl[`FLD_PRESCALE_HI:`FLD_PRESCALE_LO];
    cfg_of.count_source_sel = ctrl[`FLD_COUNT_SOURCE_SEL];
  endfunction

endpackage

// File: hw/timer_lane.sv
// One timer lane: pin synchroniser, source select, gate and prescaler
`timescale 1ns/1ps
module timer_lane (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings and device state
  input timer_pair_pkg::lane_cfg_t cfg,
  input wire logic idle_mode,
  input wire logic clock_pin,
  // Count enable
  output logic tick
);
  import timer_pair_pkg::*;

  logic s1, s2, s3, level;
  logic [7:0] pre_cnt;
  logic source_event;
  logic running;
  logic rise;

  assign rise = (s2 == s3) && s3 && !level;
  assign running = cfg.run && !(cfg.idle_halt && idle_mode);

  always_comb begin
    if (cfg.count_source_sel) begin
      source_event = rise;
    end else if (cfg.gated_accumulate) begin
      source_event = level;
    end else begin
      source_event = 1'b1;
    end
  end

  // Pin synchroniser with agreement filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= clock_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

  // Prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      pre_cnt <= 8'h00;
    end else if (source_event) begin
      if (pre_cnt == prescale_last(cfg.input_prescale_sel)) begin
        pre_cnt <= 8'h00;
      end else begin
        pre_cnt <= pre_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= running && source_event && (pre_cnt == prescale_last(cfg.input_prescale_sel));
    end
  end

  property p_idle_halt;
    @(posedge aclk) disable iff (!aresetn)
    cfg.idle_halt && idle_mode |=> !tick;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("tick while halted in idle");

  property p_ext_ignores_gate;
    @(posedge aclk) disable iff (!aresetn)
    cfg.count_source_sel && !rise |=> !tick;
  endproperty
  a_ext_ignores_gate: assert property (p_ext_ignores_gate) else $error("tick without pin edge");

  property p_gate_closed;
    @(posedge aclk) disable iff (!aresetn)
    !cfg.count_source_sel && cfg.gated_accumulate && !level |=> !tick;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("tick with gate low");

  property p_prescale_ratio;
    @(posedge aclk) disable iff (!aresetn)
    tick && $stable(cfg) |-> $past(pre_cnt) == prescale_last(cfg.input_prescale_sel);
  endproperty
  a_prescale_ratio: assert property (p_prescale_ratio) else $error("wrong prescale ratio");

  property p_internal_count;
    @(posedge aclk) disable iff (!aresetn)
    running && !cfg.count_source_sel && !cfg.gated_accumulate &&
      cfg.input_prescale_sel == 2'b00 |=> tick;
  endproperty
  a_internal_count: assert property (p_internal_count) else $error("internal clock not counted");

endmodule

// File: tb/timer_pair_tb_top.sv
// Self-checking bench for the timer pair
`timescale 1ns/1ps
`include "timer_pair_consts.svh"
module timer_pair_tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [4:0] awaddr = 0;
  logic [4:0] araddr = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, c0;
  logic idle_mode = 0;
  logic pin_a = 0;
  logic pin_b = 0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int hs = 0;
  int d, t, r;

  timer_pair u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .idle_mode(idle_mode), .ext_clock_pin_a(pin_a), .ext_clock_pin_b(pin_b), .irq(irq)
  );

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    failures++;
    $display("wrong value handshake expected done seen timeout");
    print_verdict();
  endtask

  task automatic check_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  // Write access; hs holds the cycle of the address handshake
  task automatic wr(input logic [4:0] a, input logic [31:0] dat);
    logic ok;
    ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 0;
        hs = cyc;
      end
      if (wvalid && wready) begin
        wvalid <= 0;
      end
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 0;
        ok = 1;
      end
    end
    if (!ok) begin
      timed_out();
    end
  endtask

  // Read access into rd and resp
  task automatic rdt(input logic [4:0] a);
    logic ok;
    ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 0;
      end
      if (rvalid && rready) begin
        rd = rdata;
        resp = rresp;
        rready <= 0;
        ok = 1;
      end
    end
    if (!ok) begin
      timed_out();
    end
  endtask

  // Run lower timer for w cycles; pin mode 1 square of 8, 2 high first half
  task automatic seg(input logic [15:0] ctl, input int w, input int pm);
    rdt(`OFS_COUNT_A);
    c0 = rd;
    wr(`OFS_TIMER_A_CONTROL, {16'h0, ctl});
    t = hs;
    for (int i = 0; i < w; i++) begin
      @(posedge aclk);
      pin_a <= (pm == 1) ? ((i % 8) < 4) : (pm == 2 && i < w / 2);
    end
    @(posedge aclk);
    pin_a <= 0;
    wr(`OFS_TIMER_A_CONTROL, {16'h0, ctl & 16'h7fff});
    d = hs - t;
    repeat (8) @(posedge aclk);
    rdt(`OFS_COUNT_A);
    rd = {16'h0, rd[15:0] - c0[15:0]};
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    for (int a = 0; a < 24; a += 4) begin
      rdt(a[4:0]);
      check_eq("reset value", 32'h0, rd);
    end
    end_test("reset");
    wr(`OFS_TIMER_A_CONTROL, 32'hffffffff);
    rdt(`OFS_TIMER_A_CONTROL);
    check_eq("control a", 32'h0000a07a, rd);
    wr(`OFS_TIMER_B_CONTROL, 32'hffffffff);
    rdt(`OFS_TIMER_B_CONTROL);
    check_eq("control b", 32'h0000a072, rd);
    wr(`OFS_TIMER_A_CONTROL, 32'h0);
    check_eq("bresp", 32'h0, resp);
    wr(`OFS_TIMER_B_CONTROL, 32'h0);
    rdt(5'h18);
    check_eq("unmapped rresp", 32'h2, resp);
    check_eq("unmapped rdata", 32'h0, rd);
    wr(5'h18, 32'h1);
    check_eq("unmapped bresp", 32'h2, resp);
    end_test("registers");
    // Upper timer runs alone from here, some thousands of ticks ahead of the lower
    wr(`OFS_TIMER_B_CONTROL, 32'h00008000);
    for (int k = 0; k < 4; k++) begin
      r = (k == 3) ? 256 : (1 << (3 * k));
      seg(16'h8000 | 16'(k << 4), 1024, 0);
      check_rng("prescaled count", d / r - 1, d / r + 2, rd);
    end
    rdt(`OFS_COUNT_A);
    c0 = rd;
    repeat (20) @(posedge aclk);
    rdt(`OFS_COUNT_A);
    check_eq("stopped count", c0, rd);
    end_test("prescale");
    idle_mode <= 1;
    seg(16'ha000, 200, 0);
    check_rng("idle halted", 0, 0, rd);
    seg(16'h8000, 200, 0);
    check_rng("idle running", d - 1, d + 2, rd);
    idle_mode <= 0;
    end_test("idle");
    seg(16'h8002, 400, 1);
    check_rng("pin count", 50, 50, rd);
    seg(16'h8000, 400, 1);
    check_rng("internal count", d - 1, d + 2, rd);
    seg(16'h8042, 400, 1);
    check_rng("pin gated count", 50, 50, rd);
    seg(16'h8040, 400, 2);
    check_rng("gated count", 198, 202, rd);
    end_test("source");
    // Lower word brought just below its roll-over while the upper one wraps alone
    rdt(`OFS_COUNT_A);
    c0 = rd;
    wr(`OFS_TIMER_A_CONTROL, 32'h00008000);
    repeat (32'h0000fe00 - c0) @(posedge aclk);
    wr(`OFS_TIMER_A_CONTROL, 32'h0);
    check_eq("irq masked", 32'h0, irq);
    wr(`OFS_EVENT_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    check_eq("irq raised", 32'h1, irq);
    rdt(`OFS_EVENT_STATUS);
    check_eq("status", 32'h2, rd);
    repeat (2) @(posedge aclk);
    check_eq("irq cleared", 32'h0, irq);
    wr(`OFS_EVENT_MASK, 32'h3);
    // Wide mode with the upper control still set to run on its own
    wr(`OFS_TIMER_A_CONTROL, 32'h00000008);
    rdt(`OFS_COUNT_A);
    c0[15:0] = rd[15:0];
    rdt(`OFS_COUNT_B);
    c0[31:16] = rd[15:0];
    wr(`OFS_TIMER_A_CONTROL, 32'h00008008);
    t = hs;
    repeat (1000) @(posedge aclk);
    wr(`OFS_TIMER_A_CONTROL, 32'h00000008);
    d = hs - t;
    check_eq("irq wide", 32'h0, irq);
    rdt(`OFS_EVENT_STATUS);
    check_eq("wide status", 32'h0, rd);
    rdt(`OFS_COUNT_A);
    c0 = {16'h0, rd[15:0]} - c0;
    rdt(`OFS_COUNT_B);
    rd = c0 + {rd[15:0], 16'h0};
    check_rng("wide count", d - 1, d + 2, rd);
    wr(`OFS_TIMER_B_CONTROL, 32'h0);
    wr(`OFS_TIMER_A_CONTROL, 32'h0);
    wr(`OFS_EVENT_MASK, 32'h0);
    end_test("wide");
    print_verdict();
  end
endmodule
